// ---- rtl/spi_port.sv ----
// Serial peripheral port with master and slave roles, seen at its pins.
//
// Contract
// [RULE_01] Master gives one clock cycle per bit.
// [RULE_02] Clock toggles only during a word, else idle.
// [RULE_03] Slave ignores clock edges while deselected.
// [RULE_04] Launch on one edge, sample on the other.
// [RULE_05] Polarity and phase choose launch and sample edges.
// [RULE_06] Slave select input is active low.
// [RULE_07] Master flags error when select input goes low.
// [RULE_08] Master drives flag outputs as slave selects.
// [RULE_09] Master-out line transmits as master, receives as slave.
// [RULE_10] Master-in line receives as master, transmits as slave.
// [RULE_11] Open-drain select makes slave output open drain.
// [RULE_12] Slave output disable stops driving master-in line.
// [RULE_13] Only one slave drives master-in line at once.
// [RULE_14] Pins released with pull-ups during and after reset.
// [RULE_15] Multi-master error kept in a readable sticky flag.
`timescale 1ns/100ps
`include "spi_port_defines.svh"
module spi_port #(
  parameter int WORD_W = `SPI_WORD_W,
  parameter int FIFO_DEPTH = `SPI_FIFO_DEPTH,
  parameter int DIV_W = `SPI_DIV_W,
  parameter int FLAG_N = `SPI_FLAG_N
) (
  input wire logic clk_i, // Core clock, 25 MHz.
  input wire logic nrst_i, // Synchronous reset, active low.
  input wire logic enable_i, // Port enabled.
  input wire logic master_i, // 1 master, 0 slave.
  input wire logic cpol_i, // Idle level of the serial clock.
  input wire logic cpha_i, // 0 sample on leading edge, 1 on trailing.
  input wire logic [DIV_W-1:0] clk_div_i, // Half period minus one, in core cycles.
  input wire logic open_drain_select_i, // Master-in line driven open drain.
  input wire logic slave_out_disable_i, // Never drive the master-in line.
  input wire logic [FLAG_N-1:0] flag_sel_i, // Flags used as slave selects.
  input wire logic mm_error_clr_i, // Clears the multi-master flag.
  input wire logic [WORD_W-1:0] tx_data_i, // Word to send.
  input wire logic tx_valid_i, // Word offered.
  output logic tx_ready_o, // Transmit FIFO has room.
  output logic [WORD_W-1:0] rx_data_o, // Word received.
  output logic rx_valid_o, // One-cycle pulse with a received word.
  output logic mm_error_o, // Sticky multi-master error.
  output logic busy_o, // Word in progress or slave selected.
  input wire logic sclk_i, // Serial shift clock pin, input side.
  output logic sclk_o, // Serial shift clock pin, output side.
  output logic sclk_oe_o, // Serial shift clock driven.
  input wire logic mosi_i, // Master-out line, input side.
  output logic mosi_o, // Master-out line, output side.
  output logic mosi_oe_o, // Master-out line driven.
  input wire logic miso_i, // Master-in line, input side.
  output logic miso_o, // Master-in line, output side.
  output logic miso_oe_o, // Master-in line driven.
  input wire logic slave_select_in_i, // Slave select, active low.
  output logic [FLAG_N-1:0] flag_o, // Slave select outputs, active low.
  output logic [FLAG_N-1:0] flag_oe_o, // Flag outputs driven.
  output logic pullup_en_o // Pin pull-ups enabled.
);

  localparam int EDGES = 2 * WORD_W;
  localparam int EW = $clog2(EDGES + 1);
  localparam int BW = $clog2(WORD_W);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    spi_port_pkg::master_state_t state; // Master engine state.
    logic [DIV_W-1:0] div_cnt; // Core cycles in this half period.
    logic [EW-1:0] edge_cnt; // Clock edges given in this word.
    logic [BW-1:0] bit_cnt; // Bits sampled in this word.
    logic [WORD_W-1:0] tx_sh; // Outgoing bits, MSB on the line.
    logic [WORD_W-1:0] rx_sh; // Incoming bits.
    logic sclk_prev; // Previous synchronised clock level.
    logic sel_prev; // Previous synchronised select level.
    logic sclk; // Serial clock out.
    logic sclk_oe; // Serial clock enable.
    logic mosi; // Master-out data.
    logic mosi_oe; // Master-out enable.
    logic miso; // Master-in data.
    logic miso_oe; // Master-in enable.
    logic [FLAG_N-1:0] flag; // Flag levels.
    logic [FLAG_N-1:0] flag_oe; // Flag enables.
    logic [WORD_W-1:0] rx_data; // Last received word.
    logic rx_valid; // Received word pulse.
    logic mm_error; // Sticky multi-master error.
    logic busy; // Activity.
    logic pullup_en; // Pull-up control.
  } port_state_t;

  port_state_t q;
  port_state_t next_q;
  logic [`SPI_SYNC_N-1:0] pins_s; // Synchronised pin inputs.
  logic sclk_s;
  logic sel_s;
  logic rx_in;
  logic fifo_valid;
  logic [WORD_W-1:0] fifo_data;
  logic fifo_pop;
  logic m_edge;
  logic s_edge;
  logic is_lead;
  logic sample;
  logic launch;
  logic slave_sel;

  if (WORD_W < 2 || DIV_W < 1 || FLAG_N < 1) begin : g_bad_param
    $error("spi_port needs WORD_W of at least two and nonzero widths.");
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers and transmit FIFO
  // --------------------------------------------------------------------------
  spi_sync2 #(.WIDTH(`SPI_SYNC_N)) u_sync (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .async_i({slave_select_in_i, miso_i, mosi_i, sclk_i}),
    .sync_o(pins_s)
  );

  // Both roles draw outgoing words from here, so a writer is stalled when full.
  spi_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .in_data_i(tx_data_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .out_data_o(fifo_data),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop)
  );

  assign sclk_s = pins_s[`SPI_LANE_SCLK];
  assign sel_s = pins_s[`SPI_LANE_SEL];

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  // One process runs both roles; only one of them is live at a time.
  always_comb begin
    next_q = q;
    next_q.rx_valid = 1'b0;
    next_q.sclk_prev = sclk_s;
    next_q.sel_prev = sel_s;
    fifo_pop = 1'b0;
    m_edge = 1'b0;
    is_lead = 1'b0;
    rx_in = master_i ? pins_s[`SPI_LANE_MISO] : pins_s[`SPI_LANE_MOSI]; // [RULE_09] [RULE_10]
    slave_sel = enable_i && !master_i && !sel_s; // [RULE_06]
    // Master engine: one full clock cycle per bit, parked otherwise.
    unique case (q.state)
      spi_port_pkg::ST_IDLE: begin
        next_q.sclk = cpol_i; // [RULE_02]
        if (enable_i && master_i && !q.mm_error && sel_s && fifo_valid) begin
          fifo_pop = 1'b1;
          next_q.tx_sh = fifo_data;
          next_q.state = spi_port_pkg::ST_XFER;
          next_q.div_cnt = '0;
          next_q.edge_cnt = '0;
          next_q.bit_cnt = '0;
        end
      end
      spi_port_pkg::ST_XFER: begin
        if (!enable_i || !master_i || !sel_s) begin
          // Another master or a role change ends the word at once.
          next_q.state = spi_port_pkg::ST_IDLE;
          next_q.sclk = cpol_i;
        end else if (q.div_cnt == clk_div_i) begin
          next_q.div_cnt = '0;
          if (q.edge_cnt == EW'(EDGES)) begin
            // Selects stay low a half period past the last edge, so it is still seen.
            next_q.state = spi_port_pkg::ST_IDLE; // [RULE_02]
          end else begin
            next_q.sclk = !q.sclk; // [RULE_01]
            next_q.edge_cnt = q.edge_cnt + 1'b1;
            m_edge = 1'b1;
            is_lead = !q.edge_cnt[0];
          end
        end else begin
          next_q.div_cnt = q.div_cnt + 1'b1;
        end
      end
    endcase
    // Slave edges count only while selected; deselect restarts the word.
    s_edge = slave_sel && (sclk_s != q.sclk_prev); // [RULE_03]
    if (s_edge) begin
      is_lead = sclk_s != cpol_i;
    end
    if (!master_i && (sel_s || !enable_i)) begin
      next_q.bit_cnt = '0; // [RULE_03]
    end
    if (slave_sel && q.sel_prev) begin
      // Fresh selection: present the first word before any edge.
      fifo_pop = fifo_valid;
      next_q.tx_sh = fifo_valid ? fifo_data : '0;
      next_q.bit_cnt = '0;
    end
    // Phase picks which edge samples; the other one launches.
    sample = (m_edge || s_edge) && (is_lead != cpha_i); // [RULE_04] [RULE_05]
    launch = (m_edge || s_edge) && (is_lead == cpha_i) && (q.bit_cnt != '0); // [RULE_04]
    if (sample) begin
      next_q.rx_sh = {q.rx_sh[WORD_W-2:0], rx_in};
      if (q.bit_cnt == BW'(WORD_W - 1)) begin
        next_q.bit_cnt = '0;
        next_q.rx_data = {q.rx_sh[WORD_W-2:0], rx_in};
        next_q.rx_valid = 1'b1;
        if (!master_i) begin
          fifo_pop = fifo_valid;
          next_q.tx_sh = fifo_valid ? fifo_data : '0;
        end
      end else begin
        next_q.bit_cnt = q.bit_cnt + 1'b1;
      end
    end
    if (launch) begin
      next_q.tx_sh = {q.tx_sh[WORD_W-2:0], 1'b0};
    end
    // Error is sticky; a new low select wins over a clear.
    next_q.mm_error = (q.mm_error && !mm_error_clr_i) ||
      (enable_i && master_i && !sel_s); // [RULE_07] [RULE_15]
    // Pin drivers follow the role.
    next_q.sclk_oe = enable_i && master_i && !next_q.mm_error;
    next_q.mosi_oe = enable_i && master_i && !next_q.mm_error; // [RULE_09]
    next_q.mosi = next_q.tx_sh[WORD_W-1];
    next_q.miso = open_drain_select_i ? 1'b0 : next_q.tx_sh[WORD_W-1]; // [RULE_11]
    next_q.miso_oe = slave_sel && !slave_out_disable_i &&
      (!open_drain_select_i || !next_q.tx_sh[WORD_W-1]); // [RULE_10] [RULE_11] [RULE_12]
    next_q.flag_oe = (enable_i && master_i) ? flag_sel_i : '0; // [RULE_08]
    next_q.flag = ~(flag_sel_i & {FLAG_N{next_q.state == spi_port_pkg::ST_XFER}}); // [RULE_08]
    next_q.busy = (next_q.state == spi_port_pkg::ST_XFER) || slave_sel;
    next_q.pullup_en = `SPI_PULLUP_RST;
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  // Reset releases every pin with pull-ups on; the select pin is input only.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.state <= spi_port_pkg::ST_IDLE;
      q.sclk_oe <= `SPI_OE_RST; // [RULE_14]
      q.mosi_oe <= `SPI_OE_RST; // [RULE_14]
      q.miso_oe <= `SPI_OE_RST; // [RULE_14]
      q.flag <= FLAG_N'(`SPI_FLAG_RST);
      q.pullup_en <= `SPI_PULLUP_RST; // [RULE_14]
      q.sclk_prev <= 1'b1;
      q.sel_prev <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign sclk_o = q.sclk;
  assign sclk_oe_o = q.sclk_oe;
  assign mosi_o = q.mosi;
  assign mosi_oe_o = q.mosi_oe;
  assign miso_o = q.miso;
  assign miso_oe_o = q.miso_oe;
  assign flag_o = q.flag;
  assign flag_oe_o = q.flag_oe;
  assign rx_data_o = q.rx_data;
  assign rx_valid_o = q.rx_valid;
  assign mm_error_o = q.mm_error;
  assign busy_o = q.busy;
  assign pullup_en_o = q.pullup_en;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_word_end;
    q.state == spi_port_pkg::ST_XFER ##1 q.state == spi_port_pkg::ST_IDLE;
  endsequence

  sequence s_clean_master;
    enable_i && master_i && sel_s && !q.mm_error;
  endsequence

  property p_word_edges;
    (s_clean_master ##0 s_word_end) |-> q.edge_cnt == EW'(EDGES);
  endproperty

  a_word_edges: assert property (p_word_edges) // [RULE_01] [RULE_02]
    else $error("Word ended with wrong edge count.");
  a_idle_clock: assert property (q.state == spi_port_pkg::ST_IDLE ##1 // [RULE_02]
    q.state == spi_port_pkg::ST_IDLE |-> q.sclk == $past(cpol_i))
    else $error("Serial clock not parked at idle level.");
  a_slave_ignore: assert property (!master_i && sel_s ##1 !master_i |-> // [RULE_03]
    q.bit_cnt == '0)
    else $error("Slave counted bits while deselected.");
  a_launch_edge: assert property (q.state == spi_port_pkg::ST_XFER && // [RULE_04]
    $past(q.state == spi_port_pkg::ST_XFER) && $changed(q.tx_sh) |-> $past(launch))
    else $error("Master data moved off its launch edge.");
  a_rx_word: assert property (q.rx_valid |-> $past(sample) && // [RULE_05]
    $past(q.bit_cnt) == BW'(WORD_W - 1))
    else $error("Word delivered before all bits sampled.");
  a_mm_flag_set: assert property (enable_i && master_i && !sel_s |=> // [RULE_07] [RULE_15]
    q.mm_error ##1 (q.mm_error || $past(mm_error_clr_i)))
    else $error("Multi-master error not held.");
  a_line_roles: assert property (!(q.mosi_oe && q.miso_oe)) // [RULE_09] [RULE_10]
    else $error("Both data lines driven at once.");
  a_open_drain: assert property (q.miso_oe && $past(open_drain_select_i) |-> // [RULE_11]
    !q.miso)
    else $error("Open-drain line driven high.");
  a_out_disable: assert property (slave_out_disable_i |=> !q.miso_oe) // [RULE_12]
    else $error("Disabled slave output still driven.");

endmodule : spi_port

// ---- shared/spi_port_defines.svh ----
// Constants for the serial peripheral port: widths, counts and reset values.
`ifndef SPI_PORT_DEFINES_SVH
`define SPI_PORT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define SPI_WORD_W 8
`define SPI_FIFO_DEPTH 4
`define SPI_DIV_W 8
`define SPI_FLAG_N 4
`define SPI_SYNC_N 4

// ----------------------------------------------------------------------------
// Synchroniser lane positions for the pin inputs
// ----------------------------------------------------------------------------
`define SPI_LANE_SCLK 0
`define SPI_LANE_MOSI 1
`define SPI_LANE_MISO 2
`define SPI_LANE_SEL 3

// ----------------------------------------------------------------------------
// Reset values of pin controls
// ----------------------------------------------------------------------------
`define SPI_OE_RST 1'b0
`define SPI_PULLUP_RST 1'b1
`define SPI_FLAG_RST 4'hF

`endif

// ---- shared/spi_port_pkg.sv ----
// Types shared by the serial peripheral port design files.
package spi_port_pkg;

  // --------------------------------------------------------------------------
  // Master engine states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01, // Clock parked at its idle level.
    ST_XFER = 2'b10  // Clock toggling for one word.
  } master_state_t;

endpackage : spi_port_pkg

// ---- rtl/spi_sync2.sv ----
// Two-stage synchroniser for pin inputs.
`timescale 1ns/100ps
module spi_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // Core clock.
  input wire logic nrst_i, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] async_i, // Levels from outside the clock domain.
  output logic [WIDTH-1:0] sync_o // Levels safe to read.
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] first; // Only the second stage reads this stage.
    logic [WIDTH-1:0] second; // Settled copy.
  } sync_state_t;

  sync_state_t q;
  sync_state_t next_q;

  if (WIDTH < 1) begin : g_bad_width
    $error("spi_sync2 needs WIDTH of at least one.");
  end

  // Shift both stages; reset to all ones, the pulled-up pin level.
  always_comb begin
    next_q.first = async_i;
    next_q.second = q.first;
  end

  // Register the stages.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '1;
    end else begin
      q <= next_q;
    end
  end

  assign sync_o = q.second;

endmodule : spi_sync2

// ---- rtl/spi_fifo.sv ----
// Small word FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module spi_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk_i, // Core clock.
  input wire logic nrst_i, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] in_data_i, // Word offered by the source.
  input wire logic in_valid_i, // Source offers a word.
  output logic in_ready_o, // Space for a word, registered.
  output logic [WIDTH-1:0] out_data_o, // Oldest word.
  output logic out_valid_o, // A word is held, registered.
  input wire logic out_ready_i // Sink takes the oldest word.
);

  localparam int AW = $clog2(DEPTH);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem; // Word storage.
    logic [AW-1:0] wr_ptr; // Next slot to write.
    logic [AW-1:0] rd_ptr; // Oldest slot.
    logic [AW:0] count; // Words held.
    logic in_ready; // Not full.
    logic out_valid; // Not empty.
  } fifo_state_t;

  fifo_state_t q;
  fifo_state_t next_q;
  logic push;
  logic pop;

  // Pointers wrap by overflow, so only powers of two are served.
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad_size
    $error("spi_fifo needs DEPTH a power of two of at least two.");
  end

  // Work out the next contents; flags are computed ahead so they leave flops.
  always_comb begin
    next_q = q;
    push = in_valid_i && q.in_ready;
    pop = q.out_valid && out_ready_i;
    if (push) begin
      next_q.mem[q.wr_ptr] = in_data_i;
      next_q.wr_ptr = q.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_q.rd_ptr = q.rd_ptr + 1'b1;
    end
    unique case ({push, pop})
      2'b10: next_q.count = q.count + 1'b1;
      2'b01: next_q.count = q.count - 1'b1;
      default: next_q.count = q.count;
    endcase
    next_q.in_ready = next_q.count != (AW + 1)'(DEPTH);
    next_q.out_valid = next_q.count != '0;
  end

  // Register; ready rises at the first edge after reset is released.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign in_ready_o = q.in_ready;
  assign out_valid_o = q.out_valid;
  assign out_data_o = q.mem[q.rd_ptr];

endmodule : spi_fifo

// ---- testbench/spi_slave_model.sv ----
// Behavioural external slave device facing the serial port.
`timescale 1ns/100ps
module spi_slave_model (
  input wire logic cpol_i, // Idle clock level.
  input wire logic cpha_i, // Clock phase.
  input wire logic sclk_i, // Serial shift clock line.
  input wire logic sel_n_i, // Select, active low.
  input wire logic mosi_i, // Data from the master.
  input wire logic [7:0] tx_byte_i, // Byte to return.
  output logic miso_o, // Data to the master.
  output logic miso_oe_o, // Data line driven.
  output logic [7:0] rx_byte_o // Last byte received.
);
  // --------------------------------------------------------------------------
  // Shift engine
  // --------------------------------------------------------------------------
  logic [7:0] sh; // Outgoing bits.
  logic [7:0] rx; // Incoming bits.
  logic first; // No launch edge yet in this word.
  initial begin
    miso_o = 1'b0;
    miso_oe_o = 1'b0;
    rx_byte_o = 8'h00;
  end
  // Selection loads the word and shows bit 7 at once.
  always @(negedge sel_n_i) begin
    sh = tx_byte_i;
    first = 1'b1;
    miso_oe_o = 1'b1;
    miso_o = tx_byte_i[7];
  end
  // Deselected, the line is let go so only one slave ever drives it.
  always @(posedge sel_n_i) begin
    miso_oe_o = 1'b0;
    miso_o = ~miso_o;
  end
  // Sample on one edge, launch on the other, as the phase picks.
  always @(sclk_i) begin
    if (sel_n_i === 1'b0) begin
      if ((sclk_i !== cpol_i) ^ cpha_i) begin
        rx = {rx[6:0], mosi_i};
        rx_byte_o = rx;
      end else if (first && cpha_i) begin
        first = 1'b0; // Bit 7 is already on the line.
      end else begin
        sh = {sh[6:0], 1'b0};
        miso_o = sh[7];
      end
    end
  end
endmodule : spi_slave_model

// ---- testbench/spi_port_bench.sv ----
// Self-checking bench for the serial port with an external slave model.
`timescale 1ns/100ps
module spi_port_bench;
  // --------------------------------------------------------------------------
  // Stimulus, pins and bookkeeping
  // --------------------------------------------------------------------------
  logic clk_i, nrst_i, en, mst, cpol, cpha, od, dis, mm_clr, tx_valid, sel_in;
  logic bsclk, bmosi, bdrv, m_miso, m_oe, tx_ready, rx_valid, mm_err, busy, pu, ps;
  logic sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic [7:0] div, tx_data, slv_tx, rx_data, m_rx;
  logic [3:0] fsel, flag, flag_oe;
  logic [7:0] rxq[$]; // Words seen on rx_valid.
  int n_mismatch, num_checks;
  int n_edge = 0; // Serial clock changes seen.
  // Undriven lines float high on their pull-ups.
  wire sclk_w = sclk_oe ? sclk_o : (bdrv ? bsclk : 1'b1);
  wire mosi_w = mosi_oe ? mosi_o : (bdrv ? bmosi : 1'b1);
  wire miso_w = miso_oe ? miso_o : (m_oe ? m_miso : 1'b1);
  wire sel_w = flag_oe[0] ? flag[0] : 1'b1;

  spi_port i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .enable_i(en), .master_i(mst), .cpol_i(cpol),
    .cpha_i(cpha), .clk_div_i(div), .open_drain_select_i(od), .slave_out_disable_i(dis),
    .flag_sel_i(fsel), .mm_error_clr_i(mm_clr), .tx_data_i(tx_data), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .rx_data_o(rx_data), .rx_valid_o(rx_valid), .mm_error_o(mm_err),
    .busy_o(busy), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe), .mosi_i(mosi_w),
    .mosi_o(mosi_o), .mosi_oe_o(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
    .miso_oe_o(miso_oe), .slave_select_in_i(sel_in), .flag_o(flag), .flag_oe_o(flag_oe),
    .pullup_en_o(pu)
  );
  spi_slave_model i_slave (.cpol_i(cpol), .cpha_i(cpha), .sclk_i(sclk_w), .sel_n_i(sel_w),
    .mosi_i(mosi_w), .tx_byte_i(slv_tx), .miso_o(m_miso), .miso_oe_o(m_oe), .rx_byte_o(m_rx));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // Counts clock line changes and collects received words.
  always @(posedge clk_i) begin
    ps <= sclk_w;
    if (sclk_w !== ps) n_edge <= n_edge + 1;
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
  end
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  // A wait that ran out of its bound ends the run.
  task automatic tmo(input int k, input int lim);
    if (k >= lim) begin
      n_mismatch++;
      $display("Error t=%0t got=%h exp=%h", $time, k, lim);
      print_verdict();
    end
  endtask : tmo
  // Offers one word; a spare cycle keeps valid from being set twice at once.
  task automatic push(input logic [7:0] d);
    int k;
    for (k = 0; k < 50 && tx_ready !== 1'b1; k++) @(negedge clk_i);
    tmo(k, 50);
    tx_data = d;
    tx_valid = 1'b1;
    @(negedge clk_i);
    tx_valid = 1'b0;
    @(negedge clk_i);
  endtask : push
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset;
    repeat (3) @(negedge clk_i);
    chk({1'b0, sclk_oe, mosi_oe, miso_oe, flag_oe}, 8'h00);
    nrst_i = 1'b1;
    @(negedge clk_i);
    chk({1'b0, sclk_oe, mosi_oe, miso_oe, flag_oe}, 8'h00);
    chk({3'b000, pu, flag}, 8'h1F);
  endtask : t_reset
  // Another master pulls the select low while this port is master.
  task automatic t_mm;
    int k;
    en = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(mm_err, 1'b0);
    sel_in = 1'b0;
    for (k = 0; k < 10 && mm_err !== 1'b1; k++) @(negedge clk_i);
    tmo(k, 10);
    chk(mm_err, 1'b1);
    chk(sclk_oe, 1'b0);
    // A clear while the select is still low loses to the set.
    mm_clr = 1'b1;
    @(negedge clk_i);
    mm_clr = 1'b0;
    chk(mm_err, 1'b1);
    sel_in = 1'b1;
    repeat (4) @(negedge clk_i);
    chk(mm_err, 1'b1);
    mm_clr = 1'b1;
    @(negedge clk_i);
    mm_clr = 1'b0;
    @(negedge clk_i);
    chk(mm_err, 1'b0);
    en = 1'b0;
  endtask : t_mm
  // One master word in mode m, exchanging d for s with the slave model.
  task automatic t_master(input logic [1:0] m, input logic [7:0] d, input logic [7:0] s);
    int k, e0;
    {cpol, cpha} = m;
    slv_tx = s;
    en = 1'b1;
    repeat (6) @(negedge clk_i);
    chk(sclk_w, cpol);
    e0 = n_edge;
    rxq.delete();
    push(d);
    for (k = 0; k < 500 && rxq.size() == 0; k++) @(negedge clk_i);
    tmo(k, 500);
    repeat (12) @(negedge clk_i);
    chk(rxq[0], s);
    chk(m_rx, d);
    chk(8'(n_edge - e0), 8'h10);
    chk(sclk_w, cpol);
    en = 1'b0;
  endtask : t_master
  // Fill the buffer while stopped, then let the port drain it back to back.
  task automatic t_fill;
    int k;
    // Mode 2 parks the clock at its pull-up level, so enabling makes no stray edge.
    {cpol, cpha} = 2'b10;
    slv_tx = 8'h5A;
    rxq.delete();
    for (k = 0; k < 4; k++) push(8'h10 + 8'(k));
    @(negedge clk_i);
    chk(tx_ready, 1'b0);
    en = 1'b1;
    for (k = 0; k < 2000 && rxq.size() < 4; k++) @(negedge clk_i);
    tmo(k, 2000);
    repeat (12) @(negedge clk_i);
    chk(m_rx, 8'h13);
    chk(rxq[3], 8'h5A);
    chk(tx_ready, 1'b1);
    en = 1'b0;
  endtask : t_fill
  // Bench acts as master in mode 0; stray edges come first while deselected.
  task automatic t_slave(input logic [7:0] mo, input logic [7:0] fb, input logic o,
                         input logic d);
    int i, k;
    logic [7:0] got;
    logic seen;
    {od, dis, mst, bdrv, bsclk, cpol, cpha} = {o, d, 5'b01000};
    en = 1'b1;
    push(fb);
    rxq.delete();
    seen = 1'b0;
    for (i = 0; i < 4; i++) begin
      bsclk = ~bsclk;
      repeat (4) @(negedge clk_i);
    end
    sel_in = 1'b0;
    repeat (8) @(negedge clk_i);
    chk(busy, 1'b1);
    for (i = 7; i >= 0; i--) begin
      bmosi = mo[i];
      repeat (4) @(negedge clk_i);
      bsclk = 1'b1;
      repeat (4) @(negedge clk_i);
      got[i] = miso_w;
      seen = seen | miso_oe;
      if (o && miso_oe === 1'b1) chk(miso_o, 1'b0);
      bsclk = 1'b0;
    end
    chk(mosi_oe, 1'b0);
    for (k = 0; k < 20 && rxq.size() == 0; k++) @(negedge clk_i);
    tmo(k, 20);
    sel_in = 1'b1;
    chk(rxq[0], mo);
    if (d) chk(seen, 1'b0);
    else chk(got, fb);
    repeat (8) @(negedge clk_i);
    chk(miso_oe, 1'b0);
    chk(busy, 1'b0);
  endtask : t_slave
  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial begin
    int m;
    nrst_i = 1'b0;
    mst = 1'b1;
    sel_in = 1'b1;
    div = 8'h03;
    fsel = 4'h1;
    tx_data = 8'h00;
    slv_tx = 8'h00;
    {en, cpol, cpha, od, dis, mm_clr, tx_valid, bsclk, bmosi, bdrv} = '0;
    n_mismatch = 0;
    num_checks = 0;
    t_reset();
    t_mm();
    for (m = 0; m < 4; m++) t_master(2'(m), 8'hA0 + 8'(m), 8'h5C ^ 8'(m));
    t_fill();
    t_slave(8'hC6, 8'h9A, 1'b0, 1'b0);
    t_slave(8'h35, 8'h42, 1'b1, 1'b0);
    t_slave(8'h81, 8'h7E, 1'b0, 1'b1);
    print_verdict();
  end
endmodule : spi_port_bench
